// ---- hdl/csc_pkg.sv ----
package csc_pkg;
  // ---------------------------------------------------------------
  // Delay counter
  // ---------------------------------------------------------------
  localparam int          CSC_STAGES      = 4;
  localparam int          CSC_STAGE_W     = 4;
  localparam int          CSC_CNT_W       = CSC_STAGES * CSC_STAGE_W;
  localparam logic [3:0]  CSC_STAGE_TOP   = 4'hF;
  localparam logic [15:0] CSC_CNT_RESET   = 16'h0000;
  localparam logic [15:0] CSC_TIME_END    = 16'h0010;
  localparam logic [15:0] CSC_OCC_END     = 16'h0204;
  localparam int          CSC_TIME_END_BIT = 4;
  localparam int          CSC_OCC_HI_BIT   = 9;
  localparam int          CSC_OCC_LO_BIT   = 2;
  // ---------------------------------------------------------------
  // Arm wait
  // ---------------------------------------------------------------
  localparam int          CSC_ARM_WAIT    = 1020;
  localparam int          CSC_ARM_W       = 11;
  // ---------------------------------------------------------------
  // APB map of host controller
  // ---------------------------------------------------------------
  localparam logic [7:0]  CSC_REG_CTRL    = 8'h00;
  localparam logic [7:0]  CSC_REG_DELAY   = 8'h04;
  localparam logic [7:0]  CSC_REG_STATUS  = 8'h08;
  localparam logic [7:0]  CSC_REG_FLAGS   = 8'h0C;
  localparam int          CSC_CTRL_START  = 0;
  localparam int          CSC_CTRL_MODE   = 1;
  localparam int          CSC_CTRL_MANEN  = 2;
  localparam int          CSC_CTRL_AUTOEN = 3;
  localparam int          CSC_CTRL_RELEASE = 4;
  localparam logic [31:0] CSC_DELAY_RESET = 32'h0000FFFE;

  typedef enum logic [2:0] {
    CSC_ST_READY, CSC_ST_WAIT_ARM, CSC_ST_WAIT_ENABLE, CSC_ST_WAIT_TRIGGER,
    CSC_ST_DELAYING, CSC_ST_PROCESSING
  } csc_status_type;
endpackage : csc_pkg

// ---- hdl/csc_if.sv ----
`timescale 1ns/1ps
interface csc_if;
  logic        run_start;       // Host: synchronous start of a capture run
  logic [15:0] delay_preset;    // Host: delay preset
  logic        event_select_n;  // Host: low with clock_select high = occurrence mode
  logic        clock_select;    // Host: clock select
  logic        force_enable_n;  // Host: low pulse manual, held low auto
  logic        capture_release; // Host: clears capture-active after capture
  logic [4:0]  flags;           // Device: {arm,noten,nottrig,delay,active}
  logic        end_of_capture;  // Device: end-of-capture pulse
  modport device (input run_start, delay_preset, event_select_n, clock_select,
                  force_enable_n, capture_release, output flags, end_of_capture);
  modport host (output run_start, delay_preset, event_select_n, clock_select,
                force_enable_n, capture_release, input flags, end_of_capture);
endinterface : csc_if

// ---- hdl/csc_device.sv ----
// Contract
// - Time mode: counter preset until enabled
// - No counting before trigger seen
// - Four 4-bit stages, cascaded terminal counts
// - Wrap to zero clears delay-pending
// - Time mode: end at count 16
// - Host loads inverse of delay plus one
// - End lands 22 clocks past request; code ends 19 clocks after trigger plus delay
// - Occurrence mode: events, then 516 clocks
// - Host: event low, clock high selects occurrence
// - Occurrence: count only enabled edge triggers
// - Trigger delayed one clock before counter
// - After events, end at count 516
// - Run start sets all five flags
// - Arm wait blocks enables, 1020 clocks
// - Not-enabled blocks triggers
// - Force enable pulse or hold low
// - Delay-pending blocks end, switches counting
// - Capture-active gates memory, host releases
// - All five flags readable by host
// - Host reports status by flag priority
// - Idle host starts run on arm
// - Two clock lines ORed, one active
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module csc_device
  import csc_pkg::*;
#(
  parameter int ARM_WAIT = CSC_ARM_WAIT
) (
  input  wire logic pclk,                // Internal sample clock line
  input  wire logic external_clock_line, // External sample clock line
  input  wire logic presetn,             // Async reset, active low
  input  wire logic clk_en,              // Clock enable
  input  wire logic enable_cond,         // Filtered enable condition
  input  wire logic trigger_cond,        // Edge-detected trigger, one clock
  output logic      memory_clock_en,     // Sample memory clock gate
  output logic      end_pulse_q,         // End-of-capture seen
  csc_if.device     link                 // Host side
);
  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  logic sample_clk;
  assign sample_clk = pclk | external_clock_line;

  logic       arm_q, noten_q, nottrig_q, delay_q, active_q;
  logic [CSC_ARM_W-1:0] arm_cnt_q;
  logic [15:0] cnt_q;
  logic       trig_d1_q, eoc_q;
  logic       occ_mode;
  logic [CSC_STAGES-1:0] stage_tc, stage_ce;
  logic       base_ce, end_hit;

  assign occ_mode = !link.event_select_n && link.clock_select;

  // ---------------------------------------------------------------
  // Arm wait
  // ---------------------------------------------------------------
  always_ff @(posedge sample_clk or negedge presetn) begin
    if (!presetn) begin
      arm_cnt_q <= '0;
    end else if (clk_en) begin
      if (link.run_start) begin
        arm_cnt_q <= '0;
      end else if (arm_q) begin
        arm_cnt_q <= arm_cnt_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencing flags
  // ---------------------------------------------------------------
  always_ff @(posedge sample_clk or negedge presetn) begin
    if (!presetn) begin
      arm_q     <= 1'b0;
      noten_q   <= 1'b0;
      nottrig_q <= 1'b0;
      delay_q   <= 1'b0;
      active_q  <= 1'b0;
    end else if (clk_en) begin
      if (link.run_start) begin
        arm_q     <= 1'b1;
        noten_q   <= 1'b1;
        nottrig_q <= 1'b1;
        delay_q   <= 1'b1;
        active_q  <= 1'b1;
      end else begin
        if (arm_q && arm_cnt_q == CSC_ARM_W'(ARM_WAIT - 1)) begin
          arm_q <= 1'b0;
        end
        if (!arm_q && noten_q && (enable_cond || !link.force_enable_n)) begin
          noten_q <= 1'b0;
        end
        if (!noten_q && nottrig_q && trigger_cond) begin
          nottrig_q <= 1'b0;
        end
        if (delay_q && stage_ce[CSC_STAGES-1] && &cnt_q) begin
          delay_q <= 1'b0;
        end
        if (eoc_q) begin
          active_q <= 1'b0;
        end else if (link.capture_release) begin
          active_q <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Delay counter
  // ---------------------------------------------------------------
  always_ff @(posedge sample_clk or negedge presetn) begin
    if (!presetn) begin
      trig_d1_q <= 1'b0;
    end else if (clk_en) begin
      trig_d1_q <= trigger_cond && !noten_q;
    end
  end

  always_comb begin
    if (occ_mode && delay_q) begin
      base_ce = !noten_q && trig_d1_q;
    end else begin
      base_ce = !nottrig_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CSC_STAGES; g++) begin : g_stage
      assign stage_tc[g] = cnt_q[g*4 +: 4] == CSC_STAGE_TOP;
      if (g == 0) begin : g_first
        assign stage_ce[g] = base_ce;
      end else begin : g_next
        assign stage_ce[g] = stage_ce[g-1] && stage_tc[g-1];
      end
    end
  endgenerate

  // One process owns the whole counter word
  always_ff @(posedge sample_clk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CSC_CNT_RESET;
    end else if (clk_en) begin
      for (int i = 0; i < CSC_STAGES; i++) begin
        if (link.run_start || (noten_q && !occ_mode)) begin
          cnt_q[i*4 +: 4] <= link.delay_preset[i*4 +: 4];
        end else if (stage_ce[i] && active_q) begin
          cnt_q[i*4 +: 4] <= cnt_q[i*4 +: 4] + 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // End of capture
  // ---------------------------------------------------------------
  assign end_hit = occ_mode ? (cnt_q[CSC_OCC_HI_BIT] && cnt_q[CSC_OCC_LO_BIT])
                            : cnt_q[CSC_TIME_END_BIT];

  always_ff @(posedge sample_clk or negedge presetn) begin
    if (!presetn) begin
      eoc_q <= 1'b0;
    end else if (clk_en) begin
      eoc_q <= !delay_q && active_q && end_hit && !link.run_start;
    end
  end

  always_ff @(posedge sample_clk or negedge presetn) begin
    if (!presetn) begin
      end_pulse_q     <= 1'b0;
      memory_clock_en <= 1'b0;
    end else if (clk_en) begin
      end_pulse_q     <= eoc_q;
      memory_clock_en <= active_q && !eoc_q;
    end
  end

  assign link.flags          = {arm_q, noten_q, nottrig_q, delay_q, active_q};
  assign link.end_of_capture = eoc_q;
endmodule : csc_device

// ---- hdl/csc_host.sv ----
`timescale 1ns/1ps
module csc_host
  import csc_pkg::*;
(
  input  wire logic        pclk,    // Clock
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        clk_en,  // Clock enable
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB enable
  input  wire logic        pwrite,  // APB write
  input  wire logic [7:0]  paddr,   // APB address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error
  csc_if.host              link     // Device side
);
  logic [31:0] ctrl_q, delay_q;
  logic [4:0]  flags_s1_q, flags_q;
  logic        start_q, manen_q, release_q, wr, rd, eoc_s1_q, eoc_q;
  csc_status_type status;

  assign wr = psel && penable && pwrite && clk_en;
  assign rd = psel && penable && !pwrite && clk_en;

  // ---------------------------------------------------------------
  // Flag sampling
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_s1_q <= '0;
      flags_q    <= '0;
      eoc_s1_q   <= 1'b0;
      eoc_q      <= 1'b0;
    end else if (clk_en) begin
      flags_s1_q <= link.flags;
      flags_q    <= flags_s1_q;
      eoc_s1_q   <= link.end_of_capture;
      eoc_q      <= eoc_s1_q;
    end
  end

  always_comb begin
    if (flags_q[4]) begin
      status = CSC_ST_WAIT_ARM;
    end else if (flags_q[3]) begin
      status = CSC_ST_WAIT_ENABLE;
    end else if (flags_q[2]) begin
      status = CSC_ST_WAIT_TRIGGER;
    end else if (flags_q[0]) begin
      status = CSC_ST_DELAYING;
    end else if (ctrl_q[CSC_CTRL_START]) begin
      status = CSC_ST_PROCESSING;
    end else begin
      status = CSC_ST_READY;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= '0;
      delay_q   <= CSC_DELAY_RESET;
      start_q   <= 1'b0;
      manen_q   <= 1'b0;
      release_q <= 1'b0;
    end else if (clk_en) begin
      start_q   <= 1'b0;
      manen_q   <= 1'b0;
      release_q <= 1'b0;
      if (wr && paddr == CSC_REG_CTRL) begin
        ctrl_q <= pwdata;
        start_q <= pwdata[CSC_CTRL_START] && status == CSC_ST_READY;
        manen_q <= pwdata[CSC_CTRL_MANEN];
        release_q <= pwdata[CSC_CTRL_RELEASE];
      end else if (wr && paddr == CSC_REG_DELAY) begin
        delay_q <= {16'h0000, ~(pwdata[15:0] + 16'h0001)};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > CSC_REG_FLAGS;
      unique case (paddr)
        CSC_REG_CTRL:   prdata <= ctrl_q;
        CSC_REG_DELAY:  prdata <= delay_q;
        CSC_REG_STATUS: prdata <= {28'h0000000, eoc_q, status};
        CSC_REG_FLAGS:  prdata <= {27'h0000000, flags_q};
        default:        prdata <= '0;
      endcase
    end
  end

  assign link.run_start       = start_q;
  assign link.delay_preset    = delay_q[15:0];
  assign link.event_select_n  = !ctrl_q[CSC_CTRL_MODE];
  assign link.clock_select    = ctrl_q[CSC_CTRL_MODE];
  assign link.force_enable_n  = !(manen_q || ctrl_q[CSC_CTRL_AUTOEN]);
  assign link.capture_release = release_q;
  // Rd unused beyond decode
  logic unused_rd;
  assign unused_rd = rd;
endmodule : csc_host

// ---- tb/csc_asserts.sv ----
`timescale 1ns/1ps
module csc_asserts (
  input wire logic        pclk,            // Clock
  input wire logic        presetn,         // Reset, active low
  input wire logic        run_start,       // Run start pulse
  input wire logic [15:0] delay_preset,    // Delay preset
  input wire logic        event_select_n,  // Event select
  input wire logic        clock_select,    // Clock select
  input wire logic        force_enable_n,  // Force enable
  input wire logic        capture_release, // Capture release
  input wire logic [4:0]  flags,           // Sequencing flags
  input wire logic        end_of_capture   // End pulse
);
  // ------------------------------------------------------------
  // Sequencing checks
  // ------------------------------------------------------------
  localparam int ARM_MAX = 14;
  wire occ = !event_select_n && clock_select;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_start; run_start |=> flags == 5'h1F; endproperty
  a_start: assert property (p_start) else $error("flags not set by start");
  property p_arm_hold; run_start |=> flags[4] [*4]; endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("arm wait too short");
  property p_arm_end; run_start |-> ##[2:ARM_MAX] !flags[4]; endproperty
  a_arm_end: assert property (p_arm_end) else $error("arm wait too long");
  property p_no_en; flags[4] && $past(flags[4]) |-> flags[3]; endproperty
  a_no_en: assert property (p_no_en) else $error("enable taken in arm wait");
  property p_no_trig; flags[3] && $past(flags[3]) |-> flags[2]; endproperty
  a_no_trig: assert property (p_no_trig) else $error("trigger taken before enable");
  property p_trig_first; flags[2] |-> flags[1]; endproperty
  a_trig_first: assert property (p_trig_first) else $error("delay done before trigger");
  property p_blk_end; flags[1] |-> !end_of_capture; endproperty
  a_blk_end: assert property (p_blk_end) else $error("end while delay pending");
  property p_time_end; $fell(flags[1]) && !occ |-> ##[14:19] end_of_capture; endproperty
  a_time_end: assert property (p_time_end) else $error("time mode end late");
  property p_occ_end; $fell(flags[1]) && occ |-> ##[513:520] end_of_capture; endproperty
  a_occ_end: assert property (p_occ_end) else $error("occurrence end late");
  property p_auto; !force_enable_n && !flags[4] && flags[3] |-> ##[1:3] !flags[3]; endproperty
  a_auto: assert property (p_auto) else $error("auto enable not taken");
  property p_release; capture_release |-> ##[1:2] !flags[0]; endproperty
  a_release: assert property (p_release) else $error("active not released");
endmodule : csc_asserts

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import csc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        en = 1'b1, external_source = 1'b0, enable_cond = 0, trigger_cond = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, mce, epq;
  int          n_errors = 0, compares = 0, cyc = 0, g1, g2, d1, d2;
  always #25 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  csc_if i_csc_if ();
  csc_device #(.ARM_WAIT(8)) i_csc_device (.pclk(pclk), .external_clock_line(external_source),
    .presetn(presetn), .clk_en(en), .enable_cond(enable_cond), .trigger_cond(trigger_cond),
    .memory_clock_en(mce), .end_pulse_q(epq), .link(i_csc_if));
  csc_host i_csc_host (.pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(i_csc_if));
  csc_asserts i_csc_asserts (.pclk(pclk), .presetn(presetn), .run_start(i_csc_if.run_start),
    .delay_preset(i_csc_if.delay_preset), .event_select_n(i_csc_if.event_select_n),
    .clock_select(i_csc_if.clock_select), .force_enable_n(i_csc_if.force_enable_n),
    .capture_release(i_csc_if.capture_release), .flags(i_csc_if.flags),
    .end_of_capture(i_csc_if.end_of_capture));
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_gap(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_gap
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk) penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0, r, e);
    repeat (0) @(posedge pclk);
    chk_reg(r & m, exp);
  endtask : rdc
  task automatic wait_lvl(input int b, input logic v);
    int n;
    n = 0;
    while (i_csc_if.flags[b] !== v && n < 100) begin @(posedge pclk); n++; end
    if (n >= 100) n_errors++;
  endtask : wait_lvl
  task automatic pulse();
    trigger_cond <= 1'b1;
    @(posedge pclk) trigger_cond <= 1'b0;
  endtask : pulse
  // ------------------------------------------------------------
  // One capture run; gap is trigger to end in cycles
  // ------------------------------------------------------------
  task automatic run(input logic occ, input logic au, input int d, output int gap);
    int t0, n;
    wr(CSC_REG_DELAY, d);
    rdc(CSC_REG_DELAY, {16'h0, ~(d[15:0] + 16'h0001)}, 32'hFFFF);
    wr(CSC_REG_CTRL, {28'h0, au, 1'b0, occ, 1'b1});
    wait_lvl(4, 1'b1);
    wait_lvl(4, 1'b0);
    if (!au) begin
      repeat (4) @(posedge pclk);
      pulse();
      rdc(CSC_REG_STATUS, 32'h2, 32'h7);
      wr(CSC_REG_CTRL, {28'h0, 1'b0, 1'b1, occ, 1'b1});
    end
    wait_lvl(3, 1'b0);
    repeat (3) @(posedge pclk);
    rdc(CSC_REG_STATUS, 32'h3, 32'h7);
    rdc(CSC_REG_FLAGS, 32'h7, 32'h1F);
    chk_reg({31'h0, mce}, 32'h1);
    t0 = cyc;
    for (n = 0; n < 6 && (occ || n == 0); n++) begin
      pulse();
      if (occ) repeat (19) @(posedge pclk);
    end
    n = 0;
    while (i_csc_if.end_of_capture !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
    if (n >= 3000) n_errors++;
    gap = cyc - t0;
    @(posedge pclk);
    chk_reg({31'h0, epq}, 32'h1);
    repeat (3) @(posedge pclk);
    chk_reg({31'h0, mce}, 32'h0);
    rdc(CSC_REG_STATUS, 32'h5, 32'h7);
    rdc(CSC_REG_FLAGS, 32'h0, 32'h1F);
    wr(CSC_REG_CTRL, 32'h11);
    repeat (4) @(posedge pclk);
    rdc(CSC_REG_STATUS, 32'h5, 32'h7);
    wr(CSC_REG_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    rdc(CSC_REG_STATUS, 32'h0, 32'h7);
  endtask : run
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h9070));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CSC_REG_DELAY, {16'h0, ~16'h0001}, 32'hFFFF);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk_reg(r, 32'h0);
    chk_reg({31'h0, e}, 32'h1);
    d1 = $urandom_range(9, 0);
    d2 = d1 + $urandom_range(300, 17);
    run(1'b0, 1'b0, d1, g1);
    run(1'b0, 1'b0, d2, g2);
    chk_gap(g2 - g1, d2 - d1);
    run(1'b1, 1'b1, 1, g1);
    run(1'b1, 1'b1, 3, g2);
    chk_gap(g2 - g1, 40);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    conclude();
  end
endmodule : tb
